// ---- hw/jld_core.sv ----
module jld_core
  import jld_pkg::*;
#(
  parameter bit HAS_DCACHE = 1'b1
) (
  input wire logic mclk, // Core clock.
  input wire logic rst_b, // Asynchronous reset, active low.
  input wire logic instrValid, // Instruction word present.
  input wire logic [31:0] instrWord, // Fetched instruction.
  output logic instrReady, // Block accepts the instruction.
  output logic [4:0] regReadSel, // Register file read index.
  input wire logic [31:0] regReadData, // Register file read data.
  output logic [31:0] pc, // Program counter.
  output logic regWrite, // Register write strobe.
  output logic [4:0] regWriteSel, // Register write index.
  output logic [31:0] regWriteData, // Register write data.
  output logic excValid, // Exception pulse.
  output logic [3:0] excCause, // Exception cause code.
  output logic [31:0] excAddr, // Faulting address.
  output logic cacheReq, // Data cache read request.
  output logic busReq, // System bus read request.
  output logic [31:0] memAddr, // Load byte address.
  input wire logic memAck, // Read data returned.
  input wire logic [31:0] memData, // Read word, byte lanes by address.
  input wire logic memFault, // Memory side reports a data fault.
  input wire logic [3:0] memFaultCause // Fault cause for a load.
);
  jld_decode_if dec();
  jld_state_t state;
  logic [31:0] next_pc;
  logic [31:0] effAddr;
  logic [31:0] loadAddr;
  logic [4:0] loadDst;
  logic loadSigned;
  logic loadIo;
  jld_size_t loadSize;
  logic [7:0] pickByte;
  logic [15:0] pickHalf;
  logic [31:0] loadResult;
  logic accept;
  logic jumpFault;
  logic useBus;

  jld_decoder decoder (
    .instr(instrWord),
    .dec(dec)
  );

  assign instrReady = (state == JLD_ST_IDLE);
  assign accept = instrValid && instrReady;
  assign regReadSel = dec.srcSel;
  assign effAddr = regReadData + {{16{dec.offsetField16[15]}}, dec.offsetField16};
  // A faulting jump keeps the old PC; the exception carries the bad target instead.
  assign jumpFault = (regReadData[1:0] != 2'b00);

  always_comb begin
    next_pc = pc;
    if (accept && dec.isJumpReg && !jumpFault) begin
      next_pc = regReadData;
    end else if (accept && dec.isJumpImm) begin
      next_pc = {pc[31:JLD_REGION_LSB], dec.jumpTargetField, 2'b00};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pc <= JLD_PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= JLD_ST_IDLE;
    end else begin
      case (state)
        JLD_ST_IDLE: begin
          if (accept && dec.isLoad && !(dec.loadSize == JLD_SZ_HALF && effAddr[0])) begin
            state <= JLD_ST_WAIT;
          end
        end
        JLD_ST_WAIT: begin
          if (memAck || memFault) begin
            state <= JLD_ST_DONE;
          end
        end
        JLD_ST_DONE: begin
          state <= JLD_ST_IDLE;
        end
        default: begin
          state <= JLD_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      loadAddr <= 32'h00000000;
      loadDst <= 5'h00;
      loadSigned <= 1'b0;
      loadIo <= 1'b0;
      loadSize <= JLD_SZ_BYTE;
    end else if (accept && dec.isLoad) begin
      loadAddr <= effAddr;
      loadDst <= dec.dstSel;
      loadSigned <= dec.loadSigned;
      loadIo <= dec.loadIo;
      loadSize <= dec.loadSize;
    end
  end

  // Without a cache every load goes to the bus, so the two forms are one.
  assign useBus = loadIo || !HAS_DCACHE;
  assign memAddr = loadAddr;
  assign cacheReq = (state == JLD_ST_WAIT) && !useBus;
  assign busReq = (state == JLD_ST_WAIT) && useBus;

  // Halfword lane uses bit 1 only; an odd address is stopped before issue.
  assign pickByte = memData[{loadAddr[1:0], 3'b000} +: 8];
  assign pickHalf = memData[{loadAddr[1], 4'h0} +: 16];

  always_comb begin
    loadResult = 32'h00000000;
    if (loadSize == JLD_SZ_HALF) begin
      loadResult = {{16{pickHalf[15]}}, pickHalf};
    end else if (loadSigned) begin
      loadResult = {{24{pickByte[7]}}, pickByte};
    end else begin
      loadResult = {24'h000000, pickByte};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regWrite <= 1'b0;
      regWriteSel <= 5'h00;
      regWriteData <= 32'h00000000;
    end else begin
      regWrite <= (state == JLD_ST_WAIT) && memAck && !memFault;
      if ((state == JLD_ST_WAIT) && memAck && !memFault) begin
        regWriteSel <= loadDst;
        regWriteData <= loadResult;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      excValid <= 1'b0;
      excCause <= JLD_EXC_NONE;
      excAddr <= 32'h00000000;
    end else begin
      excValid <= 1'b0;
      if (accept && dec.isJumpReg && jumpFault) begin
        excValid <= 1'b1;
        excCause <= JLD_EXC_MISALIGN_DEST;
        excAddr <= regReadData;
      end else if (accept && dec.isLoad && dec.loadSize == JLD_SZ_HALF && effAddr[0]) begin
        excValid <= 1'b1;
        excCause <= JLD_EXC_MISALIGN_DATA;
        excAddr <= effAddr;
      end else if ((state == JLD_ST_WAIT) && memFault) begin
        excValid <= 1'b1;
        excCause <= memFaultCause;
        excAddr <= loadAddr;
      end
    end
  end

  // Indirect jump: a good target lands whole, a bad one traps and the PC stays.
  jmp_target_a: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && dec.isJumpReg && !jumpFault
    |=> pc == $past(regReadData))
    else $error("indirect jump target not loaded");
  jmp_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && dec.isJumpReg && !jumpFault
    |=> !excValid)
    else $error("aligned jump raised an exception");
  jmp_fault_a: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && dec.isJumpReg && jumpFault
    |=> excValid && $stable(pc) && excCause == JLD_EXC_MISALIGN_DEST
      && excAddr == $past(regReadData))
    else $error("misaligned jump not trapped");
  jmp_decode_a: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && instrWord[JLD_OPC_MSB:JLD_OPC_LSB] == JLD_OP_RTYPE
      && instrWord[JLD_OPX_MSB:JLD_OPX_LSB] == JLD_OPX_JUMP_REG
      && instrWord[JLD_RB_MSB:JLD_RB_LSB] == 5'h00 && regReadData[1:0] == 2'b00
    |=> pc == $past(regReadData))
    else $error("indirect jump word not decoded");
  jmp_bfield_a: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && instrWord[JLD_OPC_MSB:JLD_OPC_LSB] == JLD_OP_RTYPE
      && instrWord[JLD_RB_MSB:JLD_RB_LSB] != 5'h00
    |=> $stable(pc) && !excValid)
    else $error("jump with nonzero B field taken");

  // Immediate jump keeps the region bits and takes the field as a word index.
  jmpi_field_a: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && dec.isJumpImm
    |=> pc[27:2] == $past(instrWord[31:6]))
    else $error("immediate jump target wrong");
  jmpi_opcode_a: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && instrWord[JLD_OPC_MSB:JLD_OPC_LSB] == JLD_OP_JUMP_IMM
    |=> pc == {$past(pc[31:28]), $past(instrWord[JLD_TGT_MSB:JLD_TGT_LSB]), 2'b00})
    else $error("immediate jump word not decoded");
  jmpi_region_a: assert property (@(posedge mclk) disable iff (!rst_b)
    accept && dec.isJumpImm
    |=> pc[31:28] == $past(pc[31:28]) && pc[1:0] == 2'b00 && !excValid)
    else $error("immediate jump left region");

  // Load steps: an aligned load is issued, waits on its answer, then writes.
  sequence load_issue_s;
    accept && dec.isLoad && !(dec.loadSize == JLD_SZ_HALF && effAddr[0]);
  endsequence
  sequence load_wait_s;
    (cacheReq || busReq) && memAddr == $past(effAddr);
  endsequence
  sequence load_answer_s;
    (state == JLD_ST_WAIT) && memAck && !memFault;
  endsequence
  sequence load_fault_s;
    (state == JLD_ST_WAIT) && memFault;
  endsequence
  sequence half_odd_s;
    accept && dec.isLoad && dec.loadSize == JLD_SZ_HALF && effAddr[0];
  endsequence
  load_addr_a: assert property (@(posedge mclk) disable iff (!rst_b)
    load_issue_s
    |=> load_wait_s)
    else $error("load address wrong");
  load_dst_a: assert property (@(posedge mclk) disable iff (!rst_b)
    load_issue_s
    |=> loadDst == $past(instrWord[JLD_RB_MSB:JLD_RB_LSB]))
    else $error("load destination not captured");
  plain_path_a: assert property (@(posedge mclk) disable iff (!rst_b)
    load_issue_s ##0 !dec.loadIo
    |=> cacheReq == HAS_DCACHE && busReq != HAS_DCACHE)
    else $error("ordinary load took the wrong path");
  io_bypass_a: assert property (@(posedge mclk) disable iff (!rst_b)
    load_issue_s ##0 dec.loadIo
    |=> busReq && !cacheReq)
    else $error("peripheral load used cache");
  req_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (cacheReq || busReq) && !memAck && !memFault
    |=> (cacheReq || busReq) && $stable(memAddr))
    else $error("load request dropped before answer");
  load_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
    load_answer_s
    |=> regWrite && regWriteSel == $past(loadDst) && !excValid)
    else $error("answered load not written");
  write_cause_a: assert property (@(posedge mclk) disable iff (!rst_b)
    regWrite
    |-> $past(memAck) && !$past(memFault))
    else $error("register written without an answer");

  // Load results: sign or zero extension of the selected lane.
  ubyte_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
    regWrite && !loadSigned && loadSize == JLD_SZ_BYTE
    |-> regWriteData[31:8] == 24'h000000)
    else $error("unsigned byte not zero extended");
  sbyte_sign_a: assert property (@(posedge mclk) disable iff (!rst_b)
    regWrite && loadSigned && loadSize == JLD_SZ_BYTE
    |-> regWriteData[31:8] == {24{regWriteData[7]}})
    else $error("signed byte not sign extended");
  half_sign_a: assert property (@(posedge mclk) disable iff (!rst_b)
    regWrite && loadSize == JLD_SZ_HALF
    |-> regWriteData[31:16] == {16{regWriteData[15]}})
    else $error("halfword not sign extended");

  // Faults: an odd halfword never reaches memory, a memory fault never writes.
  half_odd_a: assert property (@(posedge mclk) disable iff (!rst_b)
    half_odd_s
    |=> excValid && excCause == JLD_EXC_MISALIGN_DATA && !cacheReq && !busReq)
    else $error("odd halfword load not trapped");
  load_fault_a: assert property (@(posedge mclk) disable iff (!rst_b)
    load_fault_s
    |=> excValid && excCause == $past(memFaultCause) && excAddr == $past(loadAddr)
      && !regWrite)
    else $error("load fault not reported");
  fault_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    load_fault_s
    |=> !instrReady ##1 instrReady)
    else $error("faulted load did not return to idle");
endmodule

// ---- hw/jld_pkg.sv ----
package jld_pkg;
  localparam int JLD_XLEN = 32;
  localparam logic [5:0] JLD_OP_RTYPE = 6'h3A;
  localparam logic [5:0] JLD_OPX_JUMP_REG = 6'h0D;
  localparam logic [5:0] JLD_OP_JUMP_IMM = 6'h01;
  localparam logic [5:0] JLD_OP_LOAD_SB = 6'h07;
  localparam logic [5:0] JLD_OP_LOAD_SB_IO = 6'h27;
  localparam logic [5:0] JLD_OP_LOAD_UB = 6'h03;
  localparam logic [5:0] JLD_OP_LOAD_UB_IO = 6'h23;
  localparam logic [5:0] JLD_OP_LOAD_SH = 6'h0F;
  localparam logic [5:0] JLD_OP_LOAD_SH_IO = 6'h2F;
  localparam int JLD_OPC_LSB = 0;
  localparam int JLD_OPC_MSB = 5;
  localparam int JLD_OFS_LSB = 6;
  localparam int JLD_OFS_MSB = 21;
  localparam int JLD_RB_LSB = 22;
  localparam int JLD_RB_MSB = 26;
  localparam int JLD_RA_LSB = 27;
  localparam int JLD_RA_MSB = 31;
  localparam int JLD_OPX_LSB = 11;
  localparam int JLD_OPX_MSB = 16;
  localparam int JLD_TGT_LSB = 6;
  localparam int JLD_TGT_MSB = 31;
  localparam int JLD_REGION_LSB = 28;
  localparam logic [31:0] JLD_PC_RESET = 32'h00000000;
  localparam logic [3:0] JLD_EXC_NONE = 4'h0;
  localparam logic [3:0] JLD_EXC_MISALIGN_DEST = 4'h1;
  localparam logic [3:0] JLD_EXC_SUPER_DATA = 4'h2;
  localparam logic [3:0] JLD_EXC_MISALIGN_DATA = 4'h3;
  localparam logic [3:0] JLD_EXC_TLB_READ = 4'h4;
  localparam logic [3:0] JLD_EXC_TLB_FAST = 4'h5;
  localparam logic [3:0] JLD_EXC_TLB_DOUBLE = 4'h6;
  localparam logic [3:0] JLD_EXC_MPU_DATA = 4'h7;
  typedef enum logic [1:0] {
    JLD_SZ_BYTE = 2'b01,
    JLD_SZ_HALF = 2'b10
  } jld_size_t;
  typedef enum logic [2:0] {
    JLD_ST_IDLE = 3'b001,
    JLD_ST_WAIT = 3'b010,
    JLD_ST_DONE = 3'b100
  } jld_state_t;
endpackage

// ---- hw/jld_decode_if.sv ----
interface jld_decode_if;
  import jld_pkg::*;
  logic isJumpReg;
  logic isJumpImm;
  logic isLoad;
  logic loadSigned;
  logic loadIo;
  jld_size_t loadSize;
  logic [4:0] srcSel;
  logic [4:0] dstSel;
  logic [15:0] offsetField16;
  logic [25:0] jumpTargetField;
  modport producer (output isJumpReg, isJumpImm, isLoad, loadSigned, loadIo, loadSize,
    srcSel, dstSel, offsetField16, jumpTargetField);
  modport consumer (input isJumpReg, isJumpImm, isLoad, loadSigned, loadIo, loadSize,
    srcSel, dstSel, offsetField16, jumpTargetField);
endinterface

// ---- hw/jld_decoder.sv ----
module jld_decoder
  import jld_pkg::*;
(
  input wire logic [31:0] instr, // Instruction word.
  jld_decode_if.producer dec // Decoded fields.
);
  logic [5:0] opc;
  logic [5:0] opx;
  logic [4:0] fieldB;
  assign opc = instr[JLD_OPC_MSB:JLD_OPC_LSB];
  assign opx = instr[JLD_OPX_MSB:JLD_OPX_LSB];
  assign fieldB = instr[JLD_RB_MSB:JLD_RB_LSB];
  assign dec.srcSel = instr[JLD_RA_MSB:JLD_RA_LSB];
  assign dec.dstSel = fieldB;
  assign dec.offsetField16 = instr[JLD_OFS_MSB:JLD_OFS_LSB];
  assign dec.jumpTargetField = instr[JLD_TGT_MSB:JLD_TGT_LSB];
  assign dec.isJumpReg = (opc == JLD_OP_RTYPE) && (opx == JLD_OPX_JUMP_REG)
    && (fieldB == 5'h00);
  assign dec.isJumpImm = (opc == JLD_OP_JUMP_IMM);
  always_comb begin
    dec.isLoad = 1'b1;
    dec.loadSigned = 1'b1;
    dec.loadIo = 1'b0;
    dec.loadSize = JLD_SZ_BYTE;
    case (opc)
      JLD_OP_LOAD_SB: begin
      end
      JLD_OP_LOAD_SB_IO: begin
        dec.loadIo = 1'b1;
      end
      JLD_OP_LOAD_UB: begin
        dec.loadSigned = 1'b0;
      end
      JLD_OP_LOAD_UB_IO: begin
        dec.loadSigned = 1'b0;
        dec.loadIo = 1'b1;
      end
      JLD_OP_LOAD_SH: begin
        dec.loadSize = JLD_SZ_HALF;
      end
      JLD_OP_LOAD_SH_IO: begin
        dec.loadSize = JLD_SZ_HALF;
        dec.loadIo = 1'b1;
      end
      default: begin
        dec.isLoad = 1'b0;
      end
    endcase
  end
endmodule

// ---- dv/jld_mem_model.sv ----
module jld_mem_model (
  input wire logic mclk, // Core clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic cacheReq, // Cached read request.
  input wire logic busReq, // Uncached read request.
  input wire logic [31:0] word, // Word returned.
  input wire logic [3:0] lat, // Wait cycles.
  input wire logic fault, // Answer with a fault.
  input wire logic [3:0] cause, // Fault code.
  output logic memAck, // Data strobe.
  output logic [31:0] memData, // Read data.
  output logic memFault, // Fault strobe.
  output logic [3:0] memFaultCause // Fault code out.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitCnt;
  // Data toggles outside the answer cycle so stale data never passes for a reply.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      memAck <= 1'b0;
      memFault <= 1'b0;
      memData <= 32'h0;
      memFaultCause <= 4'h0;
      waitCnt <= 4'h0;
    end else begin
      memAck <= 1'b0;
      memFault <= 1'b0;
      memData <= ~memData;
      if ((cacheReq || busReq) && !memAck && !memFault) begin
        if (waitCnt == lat) begin
          waitCnt <= 4'h0;
          memAck <= !fault;
          memFault <= fault;
          memFaultCause <= cause;
          memData <= word;
        end else begin
          waitCnt <= waitCnt + 4'h1;
        end
      end
    end
  end
endmodule

// ---- dv/tb.sv ----
module tb import jld_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_b = 0, instrValid = 0, fault = 0;
  logic [31:0] instrWord = 0, regReadData = 0, word = 0, adr;
  logic [3:0] lat = 0, cause = 0;
  logic instrReady, regWrite, excValid, cacheReq, busReq, memAck, memFault, evExc, evWr;
  logic [4:0] regReadSel, regWriteSel;
  logic [31:0] pc, regWriteData, excAddr, memAddr, memData;
  logic [3:0] excCause, memFaultCause;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  jld_core #(.HAS_DCACHE(1'b1)) uut (.mclk(mclk), .rst_b(rst_b), .instrValid(instrValid),
    .instrWord(instrWord), .instrReady(instrReady), .regReadSel(regReadSel),
    .regReadData(regReadData), .pc(pc), .regWrite(regWrite), .regWriteSel(regWriteSel),
    .regWriteData(regWriteData), .excValid(excValid), .excCause(excCause), .excAddr(excAddr),
    .cacheReq(cacheReq), .busReq(busReq), .memAddr(memAddr), .memAck(memAck),
    .memData(memData), .memFault(memFault), .memFaultCause(memFaultCause));
  jld_mem_model mem (.mclk(mclk), .rst_b(rst_b), .cacheReq(cacheReq), .busReq(busReq),
    .word(word), .lat(lat), .fault(fault), .cause(cause), .memAck(memAck),
    .memData(memData), .memFault(memFault), .memFaultCause(memFaultCause));
  always #5 mclk = ~mclk;
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic issue(input logic [31:0] w, input logic [31:0] ra);
    @(posedge mclk);
    instrWord <= w;
    regReadData <= ra;
    instrValid <= 1'b1;
    @(posedge mclk);
    instrValid <= 1'b0;
    regReadData <= ~ra;
  endtask
  // Watches one instruction to its end and records request kind, address and events.
  task automatic waitEv(output logic [1:0] req);
    req = 2'b00;
    evExc = 1'b0;
    evWr = 1'b0;
    for (int n = 0; n < 24; n++) begin
      #1;
      if (cacheReq || busReq) begin
        req = {busReq, cacheReq};
        adr = memAddr;
      end
      evExc = evExc | excValid;
      evWr = evWr | regWrite;
      if (regWrite === 1'b1 || excValid === 1'b1) break;
      @(posedge mclk);
    end
    repeat (2) @(posedge mclk);
  endtask
  function automatic logic [31:0] ldExp(input logic [5:0] op, input logic [31:0] a, w);
    logic [7:0] b;
    logic [15:0] h;
    b = w[8*a[1:0] +: 8];
    h = w[16*a[1] +: 16];
    if (op inside {JLD_OP_LOAD_SH, JLD_OP_LOAD_SH_IO}) return {{16{h[15]}}, h};
    if (op inside {JLD_OP_LOAD_SB, JLD_OP_LOAD_SB_IO}) return {{24{b[7]}}, b};
    return {24'h0, b};
  endfunction
  task automatic jumpReg;
    logic [1:0] r;
    logic [31:0] w;
    w = {5'd4, 5'd0, 5'd0, JLD_OPX_JUMP_REG, 5'd0, JLD_OP_RTYPE};
    issue(w, 32'hA000_0010);
    waitEv(r);
    chk(pc, 32'hA000_0010);
    chk({27'h0, regReadSel}, 32'h4);
    issue(w, 32'hA000_0012);
    waitEv(r);
    chk({31'h0, evExc}, 32'h1);
    chk({28'h0, excCause}, {28'h0, JLD_EXC_MISALIGN_DEST});
    chk(excAddr, 32'hA000_0012);
    chk(pc, 32'hA000_0010);
    issue(w | 32'h0040_0000, 32'h0000_0100);
    waitEv(r);
    chk(pc, 32'hA000_0010);
  endtask
  task automatic jumpImm;
    logic [1:0] r;
    issue({26'h3FF_FFFF, JLD_OP_JUMP_IMM}, 32'h0);
    waitEv(r);
    chk(pc, 32'hAFFF_FFFC);
    chk({31'h0, evExc}, 32'h0);
    issue({26'h000_0004, JLD_OP_JUMP_IMM}, 32'h0);
    waitEv(r);
    chk(pc, 32'hA000_0010);
  endtask
  task automatic loads;
    logic [5:0] ops [6] = '{JLD_OP_LOAD_SB, JLD_OP_LOAD_SB_IO, JLD_OP_LOAD_UB,
      JLD_OP_LOAD_UB_IO, JLD_OP_LOAD_SH, JLD_OP_LOAD_SH_IO};
    logic [31:0] ra;
    logic [1:0] r;
    word <= 32'h80FF_7F81;
    for (int i = 0; i < 6; i++) begin
      lat <= 4'(i);
      ra = 32'h1000_0100 + 32'(i < 4 ? i : 2 * i - 6);
      issue({5'd3, 5'(i + 1), 16'hFFF0, ops[i]}, ra);
      waitEv(r);
      chk(adr, ra - 32'h10);
      chk({27'h0, regWriteSel}, 32'(i + 1));
      chk({27'h0, regReadSel}, 32'h3);
      chk(regWriteData, ldExp(ops[i], ra - 32'h10, word));
      chk({30'h0, r}, ops[i][5] ? 32'h2 : 32'h1);
    end
  endtask
  task automatic faults;
    logic [1:0] r;
    issue({5'd3, 5'd9, 16'h0001, JLD_OP_LOAD_SH}, 32'h2000_0000);
    waitEv(r);
    chk({28'h0, excCause}, {28'h0, JLD_EXC_MISALIGN_DATA});
    chk({29'h0, r, evWr}, 32'h0);
    chk({31'h0, evExc}, 32'h1);
    chk(excAddr, 32'h2000_0001);
    fault <= 1'b1;
    for (int c = 2; c < 8; c++) begin
      cause <= 4'(c);
      issue({5'd3, 5'd9, 16'h0004, JLD_OP_LOAD_UB_IO}, 32'h2000_0000);
      waitEv(r);
      chk({30'h0, evExc, evWr}, 32'h2);
      chk({28'h0, excCause}, 32'(c));
      chk(excAddr, 32'h2000_0004);
    end
    fault <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    chk(pc, JLD_PC_RESET);
    chk({31'h0, instrReady}, 32'h1);
    rst_b <= 1'b1;
    jumpReg;
    jumpImm;
    loads;
    faults;
    test_done;
  end
endmodule
